/* File: common/tpc_defines.svh */
// Register offsets, field positions, reset values and counts for the modulator.
// How it works
// - All four counting clocks come only from the interface clock.
// - Clocks A and B divide the input by 1 to 128, each by three bits.
// - Prescale counter stops when both channel enables are zero.
// - Scaled clocks divide A or B by reloadable count, then by two.
// - Each channel picks its prescaled clock or its scaled clock.
// - Zero duty gives inactive level; duty at least period, polarity 1, high.
// - Zero period holds counter at zero; output equals polarity.
// - Channel counter counts upward after reset.
// - After reset channels are disabled and counters stopped.
// - The modulator never raises an interrupt.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the bus.
// ****************************************************************
`define TPC_ADR_ENABLE   8'h00
`define TPC_ADR_PRESCALE 8'h04
`define TPC_ADR_CLKSEL   8'h08
`define TPC_ADR_POLARITY 8'h0C
`define TPC_ADR_SCALE_A  8'h10
`define TPC_ADR_SCALE_B  8'h14
`define TPC_ADR_PERIOD0  8'h18
`define TPC_ADR_PERIOD1  8'h1C
`define TPC_ADR_DUTY0    8'h20
`define TPC_ADR_DUTY1    8'h24
`define TPC_ADR_COUNT0   8'h28
`define TPC_ADR_COUNT1   8'h2C
`define TPC_ADR_STATUS   8'h30
`define TPC_ADR_MASK     8'hFC

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define TPC_PRE_A_LSB    0
`define TPC_PRE_B_LSB    4
`define TPC_STAT_UP_BIT  4
`define TPC_RST_BYTE     8'h00
`define TPC_RST_SCALE_CNT 8'h01
`define TPC_SCALE_LAST   8'h01

`endif

/* File: common/tpc_pkg.sv */
// Types and shared functions of the two channel modulator.
package tpc_pkg;

    // Wishbone request bundle driven by the bus master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tpc_wb_req_t;

    // Bus slave sequence.
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ACK
    } tpc_bus_state_t;

    // Whole state of the top module.
    typedef struct packed {
        tpc_bus_state_t  bus;
        logic [31:0]     rdata;
        logic [1:0]      enable;
        logic [2:0]      pre_a;
        logic [2:0]      pre_b;
        logic [1:0]      clksel;
        logic [1:0]      pol;
        logic [7:0]      scale_a;
        logic [7:0]      scale_b;
        logic [1:0][7:0] period;
        logic [1:0][7:0] duty;
        logic [1:0][7:0] cnt;
        logic [1:0]      out;
        logic            count_up;
    } tpc_state_t;

    // State of the prescale counter.
    typedef struct packed {
        logic [6:0] cnt;
    } tpc_pre_state_t;

    // State of one scaled clock divider.
    typedef struct packed {
        logic [7:0] cnt;
        logic       half;
    } tpc_scl_state_t;

    // Tick of a power of two divider taken from a free running count.
    function automatic logic tpc_div_tick(input logic [6:0] cnt,
                                          input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'(8'h01 << sel) - 7'h01;
        return (cnt & mask) == mask;
    endfunction

endpackage

/* File: design/tpc_prescaler.sv */
// Prescale counter producing the clock A and clock B ticks.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_prescaler
    import tpc_pkg::*;
(
    // Clock, reset and freeze.
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // Control.
    input  wire logic       run,
    input  wire logic [2:0] sel_a,
    input  wire logic [2:0] sel_b,
    // Ticks.
    output logic            tick_a,
    output logic            tick_b
);

    tpc_pre_state_t st_reg;
    tpc_pre_state_t st_next;

    // Counter runs only while a channel is enabled, else it rests at zero.
    always_comb begin
        st_next = st_reg;
        if (run) begin
            st_next.cnt = st_reg.cnt + 7'h01;
        end else begin
            st_next.cnt = 7'h00;
        end
    end

    // Ticks are enables on the one system clock, never derived clocks.
    assign tick_a = run && tpc_div_tick(st_reg.cnt, sel_a);
    assign tick_b = run && tpc_div_tick(st_reg.cnt, sel_b);

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

endmodule

/* File: design/tpc_scaler.sv */
// Reloadable divider followed by divide by two for a scaled clock.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_scaler
    import tpc_pkg::*;
(
    // Clock, reset and freeze.
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // Input tick and reload value; zero stands for 256.
    input  wire logic       tick_in,
    input  wire logic [7:0] scale,
    // Scaled tick.
    output logic            tick_out
);

    tpc_scl_state_t st_reg;
    tpc_scl_state_t st_next;
    logic           last;

    assign last = st_reg.cnt == `TPC_SCALE_LAST;

    // Count down on input ticks, reload at the end, toggle the halver.
    always_comb begin
        st_next = st_reg;
        if (tick_in) begin
            if (last) begin
                st_next.cnt  = scale;
                st_next.half = ~st_reg.half;
            end else begin
                st_next.cnt = st_reg.cnt - 8'h01;
            end
        end
    end

    // One tick for every second reload gives the even divisor.
    assign tick_out = tick_in && last && st_reg.half;

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg.cnt  <= `TPC_RST_SCALE_CNT;
            st_reg.half <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

endmodule

/* File: design/tpc_top.sv */
// Two channel eight bit pulse width modulator with a Wishbone slave.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_top
    import tpc_pkg::*;
(
    // Clock, reset and freeze.
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        CE,
    // Wishbone slave.
    input  wire tpc_wb_req_t WB_REQ,
    output logic [31:0]      WB_RDATA,
    output logic             WB_ACK,
    // Channel pins.
    output logic [1:0]       CHANNEL_OUTPUT
);

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    tpc_state_t st_reg;
    tpc_state_t st_next;
    logic       run;
    logic       tick_a;
    logic       tick_b;
    logic       tick_sa;
    logic       tick_sb;
    logic [1:0] tick_ch;
    logic       req;
    logic       wr_lane;
    logic [7:0] adr_w;
    logic [7:0] wbyte;

    // ****************************************************************
    // Helpers.
    // ****************************************************************

    // Output level for one channel from its settings and its count.
    function automatic logic chan_level(input logic       en,
                                        input logic       pol,
                                        input logic [7:0] per,
                                        input logic [7:0] duty,
                                        input logic [7:0] cnt);
        logic active;
        active = 1'b0;
        if (!en) begin
            chan_level = ~pol;
        end else if (per == 8'h00) begin
            chan_level = pol;
        end else begin
            // Zero duty never goes active; duty at or past period always does.
            active     = cnt < duty;
            chan_level = active ? pol : ~pol;
        end
    endfunction

    // Next count of one channel on its own tick.
    function automatic logic [7:0] chan_count(input logic       en,
                                              input logic       tick,
                                              input logic [7:0] per,
                                              input logic [7:0] cnt);
        if (!en || per == 8'h00) begin
            chan_count = 8'h00;
        end else if (!tick) begin
            chan_count = cnt;
        end else if (cnt >= per - 8'h01) begin
            chan_count = 8'h00;
        end else begin
            chan_count = cnt + 8'h01;
        end
    endfunction

    // ****************************************************************
    // Clock tree.
    // ****************************************************************

    // The prescaler input is stopped while both channels are disabled.
    assign run = |st_reg.enable;

    // Prescaler for clocks A and B.
    tpc_prescaler u_prescaler (
        .clk    (CLK),
        .resetn (RESETN),
        .ce     (CE),
        .run    (run),
        .sel_a  (st_reg.pre_a),
        .sel_b  (st_reg.pre_b),
        .tick_a (tick_a),
        .tick_b (tick_b)
    );

    // Scaled clock SA from clock A.
    tpc_scaler u_scaler_a (
        .clk      (CLK),
        .resetn   (RESETN),
        .ce       (CE),
        .tick_in  (tick_a),
        .scale    (st_reg.scale_a),
        .tick_out (tick_sa)
    );

    // Scaled clock SB from clock B.
    tpc_scaler u_scaler_b (
        .clk      (CLK),
        .resetn   (RESETN),
        .ce       (CE),
        .tick_in  (tick_b),
        .scale    (st_reg.scale_b),
        .tick_out (tick_sb)
    );

    // Channel 0 uses A or SA, channel 1 uses B or SB.
    assign tick_ch[0] = st_reg.clksel[0] ? tick_sa : tick_a;
    assign tick_ch[1] = st_reg.clksel[1] ? tick_sb : tick_b;

    // ****************************************************************
    // Bus decode.
    // ****************************************************************

    // A request is seen while the slave is idle.
    assign req     = WB_REQ.cyc && WB_REQ.stb;
    assign adr_w   = WB_REQ.adr & `TPC_ADR_MASK;
    assign wbyte   = WB_REQ.dat[7:0];
    assign wr_lane = WB_REQ.we && WB_REQ.sel[0];

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb begin
        st_next = st_reg;

        // Bus sequence: take request, answer one cycle later, then rest.
        case (st_reg.bus)
            BUS_IDLE: begin
                if (req) begin
                    st_next.bus   = BUS_ACK;
                    st_next.rdata = 32'h0000_0000;
                    case (adr_w)
                        `TPC_ADR_ENABLE: begin
                            st_next.rdata[1:0] = st_reg.enable;
                        end
                        `TPC_ADR_PRESCALE: begin
                            st_next.rdata[`TPC_PRE_A_LSB +: 3] =
                                st_reg.pre_a;
                            st_next.rdata[`TPC_PRE_B_LSB +: 3] =
                                st_reg.pre_b;
                        end
                        `TPC_ADR_CLKSEL: begin
                            st_next.rdata[1:0] = st_reg.clksel;
                        end
                        `TPC_ADR_POLARITY: begin
                            st_next.rdata[1:0] = st_reg.pol;
                        end
                        `TPC_ADR_SCALE_A: begin
                            st_next.rdata[7:0] = st_reg.scale_a;
                        end
                        `TPC_ADR_SCALE_B: begin
                            st_next.rdata[7:0] = st_reg.scale_b;
                        end
                        `TPC_ADR_PERIOD0: begin
                            st_next.rdata[7:0] = st_reg.period[0];
                        end
                        `TPC_ADR_PERIOD1: begin
                            st_next.rdata[7:0] = st_reg.period[1];
                        end
                        `TPC_ADR_DUTY0: begin
                            st_next.rdata[7:0] = st_reg.duty[0];
                        end
                        `TPC_ADR_DUTY1: begin
                            st_next.rdata[7:0] = st_reg.duty[1];
                        end
                        `TPC_ADR_COUNT0: begin
                            st_next.rdata[7:0] = st_reg.cnt[0];
                        end
                        `TPC_ADR_COUNT1: begin
                            st_next.rdata[7:0] = st_reg.cnt[1];
                        end
                        `TPC_ADR_STATUS: begin
                            st_next.rdata[1:0] = st_reg.out;
                            st_next.rdata[2]   = run;
                            st_next.rdata[`TPC_STAT_UP_BIT] =
                                st_reg.count_up;
                        end
                        default: begin
                            st_next.rdata = 32'h0000_0000;
                        end
                    endcase
                end
            end
            BUS_ACK: begin
                // Writes land at the edge where the master sees ack.
                st_next.bus = BUS_IDLE;
                if (wr_lane) begin
                    case (adr_w)
                        `TPC_ADR_ENABLE: begin
                            st_next.enable = wbyte[1:0];
                        end
                        `TPC_ADR_PRESCALE: begin
                            st_next.pre_a = wbyte[`TPC_PRE_A_LSB +: 3];
                            st_next.pre_b = wbyte[`TPC_PRE_B_LSB +: 3];
                        end
                        `TPC_ADR_CLKSEL: begin
                            st_next.clksel = wbyte[1:0];
                        end
                        `TPC_ADR_POLARITY: begin
                            st_next.pol = wbyte[1:0];
                        end
                        `TPC_ADR_SCALE_A: begin
                            st_next.scale_a = wbyte;
                        end
                        `TPC_ADR_SCALE_B: begin
                            st_next.scale_b = wbyte;
                        end
                        `TPC_ADR_PERIOD0: begin
                            st_next.period[0] = wbyte;
                        end
                        `TPC_ADR_PERIOD1: begin
                            st_next.period[1] = wbyte;
                        end
                        `TPC_ADR_DUTY0: begin
                            st_next.duty[0] = wbyte;
                        end
                        `TPC_ADR_DUTY1: begin
                            st_next.duty[1] = wbyte;
                        end
                        default: begin
                            st_next.enable = st_reg.enable;
                        end
                    endcase
                end
            end
            default: begin
                st_next.bus = BUS_IDLE;
            end
        endcase

        // The counter direction stays upward; no down mode is offered.
        st_next.count_up = 1'b1;

        // Channel counters and output levels, both from current settings.
        for (int i = 0; i < 2; i++) begin
            st_next.cnt[i] = chan_count(st_reg.enable[i], tick_ch[i],
                                        st_reg.period[i], st_reg.cnt[i]);
            st_next.out[i] = chan_level(st_reg.enable[i], st_reg.pol[i],
                                        st_reg.period[i], st_reg.duty[i],
                                        st_next.cnt[i]);
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************

    // Reset leaves channels off, counters at zero and counting up.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg          <= '0;
            st_reg.bus      <= BUS_IDLE;
            st_reg.out      <= 2'b11;
            st_reg.count_up <= 1'b1;
        end else if (CE) begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************

    // Bus answers and pin levels; no interrupt line exists.
    assign WB_ACK         = st_reg.bus == BUS_ACK;
    assign WB_RDATA       = st_reg.rdata;
    assign CHANNEL_OUTPUT = st_reg.out;

endmodule

/* File: verif/tb_tpc_top.sv */
// Self-checking bench of the two channel modulator.
`timescale 1ns/1ps
module tb_tpc_top
    import tpc_pkg::*;
();
    localparam logic [7:0] BD_DUTY [6] = '{8'h00, 8'h00, 8'h07, 8'h07,
                                           8'h05, 8'h09};
    localparam logic [7:0] BD_PER [6] = '{8'h05, 8'h05, 8'h00, 8'h00,
                                          8'h05, 8'h05};
    localparam logic BD_POL [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    localparam logic BD_LVL [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    tpc_wb_req_t wb_req = '0;
    logic [31:0] wb_rdata, rv, v;
    logic        wb_ack;
    logic [1:0]  chan_out;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          n, m, e;

    tpc_top tpc_top_inst (.CLK(clk), .RESETN(resetn), .CE(ce),
        .WB_REQ(wb_req), .WB_RDATA(wb_rdata), .WB_ACK(wb_ack),
        .CHANNEL_OUTPUT(chan_out));

    // A 50 MHz clock.
    always #10 clk = ~clk;

    // ********
    // Tasks.
    // ********
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares a value with its expectation.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A loop that used up its bound ends the run.
    task automatic guard(input int k);
        if (k >= 4000) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // One classic cycle, held until the edge that samples ack high.
    task automatic wb_cycle(input logic we, input logic [7:0] a,
                            input logic [7:0] d);
        int k;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h0, d}};
        for (k = 0; k < 4000; k++) begin
            @(posedge clk);
            if (wb_ack === 1'b1) break;
        end
        rv = wb_rdata;
        wb_req <= '0;
        guard(k);
    endtask

    // Register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb_cycle(1'b1, a, d);
    endtask

    // Register read compared with an expectation.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 8'h00);
        check(rv, exp);
    endtask

    // Length of the second whole high run of a pin, past any reload.
    task automatic high_run(input int ch, output int len);
        int k;
        repeat (2) begin
            len = 0;
            for (k = 0; k < 4000 && chan_out[ch] !== 1'b0; k++)
                @(posedge clk);
            guard(k);
            for (k = 0; k < 4000 && chan_out[ch] !== 1'b1; k++)
                @(posedge clk);
            guard(k);
            for (k = 0; k < 4000 && chan_out[ch] === 1'b1; k++) begin
                @(posedge clk);
                len++;
            end
            guard(k);
        end
    endtask

    // Expects a pin to keep one level for forty cycles.
    task automatic hold_chk(input int ch, input logic lvl);
        int bad;
        bad = 0;
        repeat (3) @(posedge clk);
        repeat (40) begin
            @(posedge clk);
            if (chan_out[ch] !== lvl) bad++;
        end
        check(bad, 0);
    endtask

    // ********
    // Scenarios.
    // ********
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        check({30'h0, chan_out}, 32'h3);
        for (int a = 0; a < 'h30; a += 4) rd_chk(8'(a), 32'h0);
        rd_chk(8'h30, 32'h13);
        wr(8'h40, 8'hFF);
        rd_chk(8'h40, 32'h0);
        wr(8'h28, 8'h55);
        rd_chk(8'h28, 32'h0);
        // Duty share within a period at both polarities.
        wr(8'h18, 8'h05);
        wr(8'h20, 8'h02);
        wr(8'h0C, 8'h01);
        wr(8'h00, 8'h01);
        high_run(0, n);
        check(n, 2);
        wr(8'h0C, 8'h00);
        high_run(0, n);
        check(n, 3);
        wb_cycle(1'b0, 8'h30, 8'h00);
        check(rv & 32'h14, 32'h14);
        // The counter climbs one step a cycle between spaced reads.
        wr(8'h18, 8'hC8);
        wb_cycle(1'b0, 8'h28, 8'h00);
        v = rv;
        wb_cycle(1'b0, 8'h28, 8'h00);
        check(rv - v, 32'h3);
        // A low clock enable freezes the count for five cycles.
        v = rv;
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        wb_cycle(1'b0, 8'h28, 8'h00);
        check(rv - v, 32'h3);
        // Each power of two on clock A and clock B, set apart.
        wr(8'h18, 8'h02);
        wr(8'h1C, 8'h02);
        wr(8'h20, 8'h01);
        wr(8'h24, 8'h01);
        wr(8'h0C, 8'h03);
        wr(8'h00, 8'h03);
        for (int k = 0; k < 8; k++) begin
            wr(8'h04, {1'b0, 3'(7 - k), 1'b0, 3'(k)});
            high_run(0, n);
            high_run(1, m);
            check(n, 1 << k);
            check(m, 1 << (7 - k));
        end
        // Scaled clocks: twice the reload count, after the prescale.
        wr(8'h08, 8'h03);
        for (int k = 0; k < 4; k++) begin
            wr(8'h04, 8'(k / 3 * 8'h11));
            wr(8'h10, 8'(k * 3 % 4));
            wr(8'h14, 8'(k * 3 % 4));
            e = (k * 3 % 4 == 0 ? 256 : k * 3 % 4) * 2 << (k / 3);
            high_run(0, n);
            high_run(1, m);
            check(n, e);
            check(m, e);
        end
        wr(8'h08, 8'h00);
        wr(8'h04, 8'h00);
        // Boundary cases on channel 0.
        for (int k = 0; k < 6; k++) begin
            wr(8'h20, BD_DUTY[k]);
            wr(8'h18, BD_PER[k]);
            wr(8'h0C, {7'h0, BD_POL[k]});
            hold_chk(0, BD_LVL[k]);
            if (BD_PER[k] == 8'h00) rd_chk(8'h28, 32'h0);
        end
        // Disabled channels idle at the inverse of polarity.
        wr(8'h00, 8'h00);
        wr(8'h0C, 8'h02);
        hold_chk(0, 1'b1);
        hold_chk(1, 1'b0);
        rd_chk(8'h28, 32'h0);
        rd_chk(8'h2C, 32'h0);
        rd_chk(8'h30, 32'h11);
        // A reset in mid-run turns running channels off again.
        wr(8'h00, 8'h03);
        rd_chk(8'h00, 32'h3);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        check({30'h0, chan_out}, 32'h3);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h30, 32'h13);
        report_and_stop();
    end
endmodule

/* File: verif/tpc_top_asserts.sv */
// Checker of the modulator pins and bus answers, bound to the top.
`timescale 1ns/1ps
module tpc_top_chk
    import tpc_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic        CLK,
    input wire logic        RESETN,
    input wire logic        CE,
    // Bus and pins.
    input wire tpc_wb_req_t WB_REQ,
    input wire logic [31:0] WB_RDATA,
    input wire logic        WB_ACK,
    input wire logic [1:0]  CHANNEL_OUTPUT
);
    logic [1:0]      en_reg, pol_reg, zp, zd, fd;
    logic [1:0][7:0] per_reg, duty_reg;
    logic [1:0]      q_reg;
    logic            wr, rd;

    assign wr = WB_ACK && WB_REQ.we && WB_REQ.sel[0];
    assign rd = WB_ACK && !WB_REQ.we;

    // Shadow settings; q_reg counts quiet cycles after the last write.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            {en_reg, pol_reg, per_reg, duty_reg, q_reg} <= '0;
        end else if (wr) begin
            q_reg <= 2'h0;
            case (WB_REQ.adr)
                8'h00: en_reg <= WB_REQ.dat[1:0];
                8'h0C: pol_reg <= WB_REQ.dat[1:0];
                8'h18: per_reg[0] <= WB_REQ.dat[7:0];
                8'h1C: per_reg[1] <= WB_REQ.dat[7:0];
                8'h20: duty_reg[0] <= WB_REQ.dat[7:0];
                8'h24: duty_reg[1] <= WB_REQ.dat[7:0];
                default: ;
            endcase
        end else if (q_reg != 2'h3) begin
            q_reg <= q_reg + 2'h1;
        end
    end

    // Channels that sit in one of the constant output cases.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            zp[i] = en_reg[i] && per_reg[i] == 8'h00;
            zd[i] = en_reg[i] && per_reg[i] != 8'h00
                    && duty_reg[i] == 8'h00;
            fd[i] = en_reg[i] && per_reg[i] != 8'h00 && pol_reg[i]
                    && duty_reg[i] >= per_reg[i];
        end
    end

    // ********
    // Properties.
    // ********
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_idle;
        q_reg == 2'h3 |-> ((CHANNEL_OUTPUT ^ ~pol_reg) & ~en_reg) == 2'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle level wrong");
    property p_zero_per;
        q_reg == 2'h3 |-> ((CHANNEL_OUTPUT ^ pol_reg) & zp) == 2'h0;
    endproperty
    a_zero_per: assert property (p_zero_per) else $error("zero period");
    property p_zero_duty;
        q_reg == 2'h3 |-> ((CHANNEL_OUTPUT ^ ~pol_reg) & zd) == 2'h0;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty");
    property p_full_duty;
        q_reg == 2'h3 |-> (~CHANNEL_OUTPUT & fd) == 2'h0;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty");
    property p_count_up;
        rd && WB_REQ.adr == 8'h30 |-> WB_RDATA[4];
    endproperty
    a_count_up: assert property (p_count_up) else $error("not up");
    property p_pre_run;
        rd && WB_REQ.adr == 8'h30 && q_reg == 2'h3
            |-> WB_RDATA[2] == (|en_reg);
    endproperty
    a_pre_run: assert property (p_pre_run) else $error("prescaler");
    property p_cnt_zero;
        rd && WB_REQ.adr[7:3] == 5'h05 && WB_REQ.adr[1:0] == 2'h0
            && q_reg == 2'h3 && (!en_reg[WB_REQ.adr[2]]
            || per_reg[WB_REQ.adr[2]] == 8'h00) |-> WB_RDATA == 32'h0;
    endproperty
    a_cnt_zero: assert property (p_cnt_zero) else $error("count");
    property p_ack_pulse;
        WB_ACK |=> !WB_ACK;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_ack_answer;
        WB_REQ.cyc && WB_REQ.stb && !WB_ACK |=> WB_ACK;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("no ack");

    c_write: cover property (wr);
    c_status: cover property (rd && WB_REQ.adr == 8'h30);
    c_zero_per: cover property (q_reg == 2'h3 && |zp);
endmodule

bind tpc_top tpc_top_chk tpc_top_chk_inst (.CLK(CLK), .RESETN(RESETN),
    .CE(CE), .WB_REQ(WB_REQ), .WB_RDATA(WB_RDATA), .WB_ACK(WB_ACK),
    .CHANNEL_OUTPUT(CHANNEL_OUTPUT));
